// File: otppp_pkg.sv
// Package with constants and carriers for the one-time PROM programming port.
// How it works
// - Programming mode presents memory as 8-bit locations, one byte each.
// - Word upper byte sits at even address, lower byte at odd address.
// - No address pins; internal counter advances on step clock pulses only.
// - Mode pins decode zero-clear, write, read/verify and program inhibit.
// - Zero-clear mode resets the byte address counter to zero.
// - Four step pulses per location advance the address by exactly one.
// - Read/verify drives each successive byte, a new one every four pulses.
// - Address increments on the falling edge of the third pulse of four.
package otppp_pkg;
    localparam int          WORDS       = 16384;
    localparam int          WORD_W      = 16;
    localparam int          BYTE_W      = 8;
    localparam int          WADDR_W     = 14;
    localparam int          BADDR_W     = WADDR_W + 1;
    localparam int          PULSES_PER  = 4;
    localparam logic [1:0]  STEP_EDGE   = 2'h2;
    localparam logic [3:0]  MODE_CLEAR  = 4'h5;
    localparam logic [3:0]  MODE_WRITE  = 4'he;
    localparam logic [3:0]  MODE_READ   = 4'hc;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    typedef enum logic [1:0] {
        OTPPP_IDLE    = 2'b00,
        OTPPP_CLEAR   = 2'b01,
        OTPPP_WRITE   = 2'b10,
        OTPPP_READ    = 2'b11
    } otppp_mode_t;

    typedef struct packed {
        logic [BYTE_W-1:0] out;
        logic              oe_n;
    } otppp_bus_t;
endpackage : otppp_pkg

// File: otppp_mem.sv
// Word memory with a registered read port and byte-lane write.
`timescale 1ns/10ps
module otppp_mem
    import otppp_pkg::*;
#(
    parameter int DEPTH = WORDS,
    parameter int AW    = WADDR_W
) (
    // Clock.
    input  wire logic                clk,
    // Write port.
    input  wire logic                wr,
    input  wire logic                wr_hi,
    input  wire logic [AW-1:0]       addr,
    input  wire logic [BYTE_W-1:0]   wdata,
    // Read data.
    output logic      [WORD_W-1:0]   rdata
);
    logic [WORD_W-1:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("otppp_mem depth exceeds address range");
        end
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = ERASED_WORD;
        end
    end

    // One-time cells only lose ones, so programming ANDs into the stored word.
    always_ff @(posedge clk) begin
        if (wr && wr_hi) begin
            mem[addr][15:8] <= mem[addr][15:8] & wdata;
        end else if (wr) begin
            mem[addr][7:0] <= mem[addr][7:0] & wdata;
        end
        rdata <= mem[addr];
    end
endmodule : otppp_mem

// File: otppp_port.sv
// Programming-mode port: mode decode, step-clock address counter, data pins.
`timescale 1ns/10ps
module otppp_port
    import otppp_pkg::*;
(
    // Clock and reset.
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Programmer pins.
    input  wire logic [3:0]          mode_select_pins,
    input  wire logic                step_clk,
    input  wire logic                program_voltage_pin,
    // Byte data pins, three-signal form.
    input  wire logic [BYTE_W-1:0]   byte_data_pins_in,
    output logic      [BYTE_W-1:0]   byte_data_pins_out,
    output logic                     byte_data_pins_oe_n,
    // Status.
    output logic [BADDR_W-1:0]       byte_addr,
    output logic [1:0]               mode
);
    logic [3:0]        md_s1, md_s2;
    logic [2:0]        ck_s;
    logic [1:0]        vp_s;
    logic [7:0]        d_s1, d_s2;
    logic [1:0]        pulse_cnt, next_pulse_cnt;
    logic [BADDR_W-1:0] next_byte_addr;
    otppp_mode_t       cur, next_cur;
    otppp_bus_t        bus, next_bus;
    logic              wr_prev, next_wr_prev;
    logic              mem_wr;
    logic [WORD_W-1:0] rword;
    logic              ck_fall;

    // Pins are asynchronous to core_clk; the first stage feeds only the second.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            md_s1 <= 4'h0;
            md_s2 <= 4'h0;
            ck_s  <= 3'h0;
            vp_s  <= 2'h0;
            d_s1  <= 8'h00;
            d_s2  <= 8'h00;
        end else begin
            md_s1 <= mode_select_pins;
            md_s2 <= md_s1;
            ck_s  <= {ck_s[1:0], step_clk};
            vp_s  <= {vp_s[0], program_voltage_pin};
            d_s1  <= byte_data_pins_in;
            d_s2  <= d_s1;
        end
    end

    assign ck_fall = ck_s[2] & ~ck_s[1];

    always_comb begin
        next_cur = OTPPP_IDLE;
        if (vp_s[1]) begin
            unique case (md_s2)
                MODE_CLEAR: next_cur = OTPPP_CLEAR;
                MODE_WRITE: next_cur = OTPPP_WRITE;
                MODE_READ:  next_cur = OTPPP_READ;
                default:    next_cur = OTPPP_IDLE;
            endcase
        end
    end

    always_comb begin
        next_pulse_cnt = pulse_cnt;
        next_byte_addr = byte_addr;
        if (cur == OTPPP_CLEAR) begin
            next_pulse_cnt = 2'h0;
            next_byte_addr = '0;
        end else if (ck_fall) begin
            // Address advances only from step-clock edges, never from pins.
            next_pulse_cnt = pulse_cnt + 2'h1;
            if (pulse_cnt == STEP_EDGE) begin
                next_byte_addr = byte_addr + 1'b1;
            end
        end
    end

    // One cell program per write-mode entry; holding write mode longer does not write again.
    assign next_wr_prev = (cur == OTPPP_WRITE);
    assign mem_wr       = (cur == OTPPP_WRITE) && !wr_prev;

    always_comb begin
        next_bus.oe_n = (next_cur != OTPPP_READ);
        // Even address selects the upper byte of the word.
        next_bus.out  = byte_addr[0] ? rword[7:0] : rword[15:8];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur       <= OTPPP_IDLE;
            pulse_cnt <= 2'h0;
            byte_addr <= '0;
            wr_prev   <= 1'b0;
            bus       <= '{out: 8'h00, oe_n: 1'b1};
        end else begin
            cur       <= next_cur;
            pulse_cnt <= next_pulse_cnt;
            byte_addr <= next_byte_addr;
            wr_prev   <= next_wr_prev;
            bus       <= next_bus;
        end
    end

    otppp_mem #(
        .DEPTH (WORDS),
        .AW    (WADDR_W)
    ) u_mem (
        .clk   (core_clk),
        .wr    (mem_wr),
        .wr_hi (~byte_addr[0]),
        .addr  (byte_addr[BADDR_W-1:1]),
        .wdata (d_s2),
        .rdata (rword)
    );

    assign byte_data_pins_out  = bus.out;
    assign byte_data_pins_oe_n = bus.oe_n;
    assign mode                = cur;
endmodule : otppp_port

// File: otppp_props.sv
// Assertions on the programming port pins and status.
`timescale 1ns/10ps
module otppp_props
    import otppp_pkg::*;
(
    // Clock, reset, pins and status.
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic [3:0]         mode_select_pins,
    input wire logic               program_voltage_pin,
    input wire logic               byte_data_pins_oe_n,
    input wire logic [BADDR_W-1:0] byte_addr,
    input wire logic [1:0]         mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Six cycles covers the two-stage synchroniser plus the mode register.
    sequence s_held(v);
        (program_voltage_pin && mode_select_pins == v) [*6];
    endsequence
    chk_clear_mode: assert property (s_held(MODE_CLEAR) |-> mode == 2'h1 && byte_addr == '0)
        else $error("clear mode");
    chk_write_mode: assert property (s_held(MODE_WRITE) |-> mode == 2'h2)
        else $error("write mode");
    chk_read_mode: assert property (s_held(MODE_READ) |-> mode == 2'h3)
        else $error("read mode");
    chk_inhibit_mode: assert property (s_held(4'hd) |-> mode == 2'h0)
        else $error("inhibit mode");
    chk_vpp_idle: assert property (!program_voltage_pin [*6] |-> mode == 2'h0)
        else $error("supply low");
    chk_step_one: assert property ($changed(byte_addr) && byte_addr != '0 |-> byte_addr == $past(byte_addr) + 1'b1)
        else $error("address step");
    chk_step_gap: assert property ($changed(byte_addr) |=> $stable(byte_addr) [*8])
        else $error("address gap");
    chk_oe_read: assert property (!byte_data_pins_oe_n |-> mode == 2'h3 || $past(mode) == 2'h3)
        else $error("drive outside read");
endmodule : otppp_props

// File: otppp_prog.sv
// Programmer model driving mode, step clock, supply and data pins.
`timescale 1ns/10ps
module otppp_prog
    import otppp_pkg::*;
(
    // Pacing clock and device pins.
    input wire logic              core_clk,
    output logic [3:0]            mode_select_pins = 4'h5,
    output logic                  step_clk = 1'b0,
    output logic                  program_voltage_pin = 1'b0,
    output logic [BYTE_W-1:0]     prog_data = 8'h00,
    input wire logic [BYTE_W-1:0] byte_data_pins_in
);
    // Write pulse in core cycles, far below 1 ms so the run stays short.
    localparam int PULSE = 20;
    int tries;
    task set_mode(input logic [3:0] m, input int n);
        @(posedge core_clk) mode_select_pins <= m;
        repeat (n) @(posedge core_clk);
    endtask : set_mode
    task step(input int n);
        repeat (n) begin
            @(posedge core_clk) step_clk <= 1'b1;
            repeat (16) @(posedge core_clk);
            step_clk <= 1'b0;
            repeat (16) @(posedge core_clk);
        end
    endtask : step
    task supply(input logic on);
        set_mode(MODE_CLEAR, 6);
        program_voltage_pin <= on;
        repeat (6) @(posedge core_clk);
    endtask : supply
    task prog_byte(input logic [7:0] b);
        tries = 0;
        prog_data <= b;
        set_mode(4'hd, 6);
        do begin
            tries++;
            set_mode(MODE_WRITE, PULSE);
            set_mode(4'hd, 6);
            set_mode(MODE_READ, 8);
        end while (byte_data_pins_in !== b && tries < 3);
        set_mode(4'hd, 6);
        set_mode(MODE_WRITE, PULSE * tries);
        set_mode(4'hd, 6);
        step(4);
    endtask : prog_byte
endmodule : otppp_prog

// File: test_otp_prom_program_port.sv
// Testbench for the programming port driven by the programmer model.
`timescale 1ns/10ps
module test_otp_prom_program_port;
    import otppp_pkg::*;
    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic [3:0]         mode_select_pins;
    logic               step_clk;
    logic               program_voltage_pin;
    logic [BYTE_W-1:0]  prog_data;
    logic [BYTE_W-1:0]  byte_data_pins_out;
    logic               byte_data_pins_oe_n;
    logic [BADDR_W-1:0] byte_addr;
    logic [1:0]         mode;
    int                 num_errors = 0;
    int                 checked = 0;
    logic [7:0]         pat [4] = '{8'ha5, 8'h3c, 8'h0f, 8'he1};
    // The programmer lets go of the data pins whenever the device drives them.
    wire [7:0] byte_data_pins_in = byte_data_pins_oe_n ? prog_data : byte_data_pins_out;
    always #2.5 core_clk = ~core_clk;
    otppp_port dut_u (.*);
    otppp_prog prog_u (.*);
    task chk(input string n, input logic [14:0] e, input logic [14:0] s);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task close_out;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    task t_write;
        prog_u.supply(1'b1);
        for (int i = 0; i < 4; i++) begin
            prog_u.prog_byte(pat[i]);
            chk("tries", 15'h1, 15'(prog_u.tries));
            chk("addr", 15'(i + 1), byte_addr);
        end
    endtask : t_write
    task t_read;
        prog_u.set_mode(MODE_CLEAR, 6);
        prog_u.step(4);
        chk("addr", 15'h0, byte_addr);
        prog_u.set_mode(MODE_READ, 8);
        for (int i = 0; i < 4; i++) begin
            chk("oe_n", 15'h0, byte_data_pins_oe_n);
            chk("data", pat[i], byte_data_pins_out);
            prog_u.step(i < 3 ? 4 : 2);
        end
        chk("addr", 15'h3, byte_addr);
        prog_u.step(1);
        chk("addr", 15'h4, byte_addr);
        prog_u.set_mode(4'hd, 6);
        chk("oe_n", 15'h1, byte_data_pins_oe_n);
        prog_u.supply(1'b0);
    endtask : t_read
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_write;
        t_read;
        close_out;
    end
    initial begin
        #100000;
        num_errors++;
        close_out;
    end
endmodule : test_otp_prom_program_port
bind otppp_port otppp_props chk_u (.*);
